//--- src/csd_pkg.sv
// Purpose: shared constants for the chip-select decoder
// Assumes: byte offsets relative to the block's own base on the register bus
// Notes: field layouts inside the address, mask and control words are local choices
package csd_pkg;
	// register map: three words per select, first select at 0x080
	localparam logic [7:0] CSD_OFF_FIRST = 8'h80;
	localparam logic [7:0] CSD_STRIDE = 8'h0c;
	localparam logic [7:0] CSD_WORD = 8'h04;
	localparam logic [1:0] CSD_KIND_BASE = 2'h0;
	localparam logic [1:0] CSD_KIND_MASK = 2'h1;
	localparam logic [1:0] CSD_KIND_CTL = 2'h2;
	localparam int CSD_MAX_SEL = 8;
	// mask word: [31:16] address mask, [1] processor-space enable, [0] valid
	localparam int CSD_HI_LSB = 16;
	localparam int CSD_MSK_VLD = 0;
	localparam int CSD_MSK_CPU = 1;
	// control word fields
	localparam int CSD_CTL_WS_LSB = 10;
	localparam int CSD_CTL_AA = 8;
	localparam int CSD_CTL_PW_LSB = 6;
	localparam int CSD_CTL_MODE = 5;
	localparam int CSD_CTL_RBURST = 4;
	localparam int CSD_CTL_WBURST = 3;
	// port width codes, same coding as the boot straps
	localparam logic [1:0] CSD_PW_32 = 2'h0;
	localparam logic [1:0] CSD_PW_8 = 2'h1;
	localparam logic [1:0] CSD_PW_16 = 2'h2;
	// transfer size codes
	localparam logic [1:0] CSD_SZ_BYTE = 2'h0;
	localparam logic [1:0] CSD_SZ_WORD = 2'h1;
	localparam logic [1:0] CSD_SZ_LONG = 2'h2;
	localparam logic [1:0] CSD_SZ_LINE = 2'h3;
	// boot strap positions within the sampled data lines 7:5
	localparam int CSD_STRAP_AA = 2;
	localparam logic [3:0] CSD_BOOT_WS = 4'hf;
	localparam logic [3:0] CSD_WS_NONE = 4'h0;
	localparam logic [1:0] CSD_RESP_OKAY = 2'h0;
	localparam logic [1:0] CSD_RESP_SLVERR = 2'h2;
	localparam logic [3:0] CSD_LANES_OFF = 4'hf;
	typedef enum logic {CSD_IDLE, CSD_ACTIVE} csd_state_type;
endpackage : csd_pkg

//--- src/csd_lane_if.sv
// Purpose: carries a lane strobe request to the lane decoder and its answer back
// Assumes: purely combinational path
// Notes: none
`timescale 1ns/1ps
interface csd_lane_if;
	logic [1:0] size;
	logic [1:0] addr_lo;
	logic [1:0] port_width;
	logic mode;
	logic write;
	logic [3:0] lane_n;
	modport requester (output size, output addr_lo, output port_width, output mode,
		output write, input lane_n);
	modport decoder (input size, input addr_lo, input port_width, input mode,
		input write, output lane_n);
endinterface : csd_lane_if

//--- src/csd_lane_decoder.sv
// Purpose: active-low lane strobes from size, low address bits and port width
// Assumes: lane 0 serves data bits 31:24
// Notes: combinational; the caller registers the result
`timescale 1ns/1ps
module csd_lane_decoder (
	csd_lane_if.decoder lane
);
	import csd_pkg::*;
	always_comb begin
		lane.lane_n = CSD_LANES_OFF;
		case (lane.port_width)
			CSD_PW_8: lane.lane_n = 4'he;
			CSD_PW_32: begin
				if (lane.size == CSD_SZ_BYTE) begin
					lane.lane_n = ~(4'h1 << lane.addr_lo);
				end else if (lane.size == CSD_SZ_WORD) begin
					lane.lane_n = lane.addr_lo[1] ? 4'h3 : 4'hc;
				end else begin
					lane.lane_n = 4'h0;
				end
			end
			default: begin
				if (lane.size == CSD_SZ_BYTE) begin
					lane.lane_n = lane.addr_lo[0] ? 4'hd : 4'he;
				end else begin
					lane.lane_n = 4'hc;
				end
			end
		endcase
		// byte write enable mode keeps the lanes quiet on reads
		if (lane.mode && !lane.write) begin
			lane.lane_n = CSD_LANES_OFF;
		end
	end
endmodule : csd_lane_decoder

//--- src/csd_chip_select.sv
// Purpose: up to eight programmable chip selects (NUM_SEL, 1 to 8) with read strobe and lane strobes
// Assumes: register access over AXI4-Lite; access request held for the whole cycle
// Notes: read strobe moves on the falling clock edge
`timescale 1ns/1ps
module csd_chip_select #(
	parameter int NUM_SEL = 8
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [2:0] i_boot_strap,
	input wire logic i_acc_valid,
	input wire logic [31:0] i_acc_addr,
	input wire logic i_acc_write,
	input wire logic [1:0] i_acc_size,
	input wire logic i_acc_cpu_space,
	input wire logic i_acc_ext_master,
	input wire logic i_dram_hit,
	output logic [NUM_SEL-1:0] o_select_n,
	output logic o_read_strobe_n,
	output logic [3:0] o_lane_strobe_n,
	output logic [1:0] o_cyc_port_width,
	output logic o_cyc_burst_en,
	output logic o_cyc_ext_term,
	output logic o_cyc_ack,
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready
);
	import csd_pkg::*;

	if (NUM_SEL < 1 || NUM_SEL > CSD_MAX_SEL) begin : g_bad_num_sel
		$error("NUM_SEL must be 1 to 8");
	end

	// {hit, index, kind}; a hit needs an aligned word of a present select
	function automatic logic [5:0] reg_decode(input logic [7:0] a);
		logic [5:0] r;
		r = 6'h0;
		for (int n = 0; n < NUM_SEL; n++) begin
			for (int k = 0; k < 3; k++) begin
				if (a == 8'(CSD_OFF_FIRST + n * CSD_STRIDE + k * CSD_WORD)) begin
					r = {1'b1, 3'(n), 2'(k)};
				end
			end
		end
		return r;
	endfunction : reg_decode

	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction : strb_merge

	// configuration per select
	logic [15:0] base_q [NUM_SEL];
	logic [15:0] mask_q [NUM_SEL];
	logic [NUM_SEL-1:0] vld_q, cpu_q, aa_q, mode_q, rburst_q, wburst_q;
	logic [3:0] ws_q [NUM_SEL];
	logic [1:0] pw_q [NUM_SEL];

	function automatic logic [31:0] reg_word(input logic [2:0] i, input logic [1:0] k);
		logic [31:0] r;
		r = 32'h0;
		case (k)
			CSD_KIND_BASE: r[CSD_HI_LSB +: 16] = base_q[i];
			CSD_KIND_MASK: begin
				r[CSD_HI_LSB +: 16] = mask_q[i];
				r[CSD_MSK_CPU] = cpu_q[i];
				r[CSD_MSK_VLD] = vld_q[i];
			end
			default: begin
				r[CSD_CTL_WS_LSB +: 4] = ws_q[i];
				r[CSD_CTL_AA] = aa_q[i];
				r[CSD_CTL_PW_LSB +: 2] = pw_q[i];
				r[CSD_CTL_MODE] = mode_q[i];
				r[CSD_CTL_RBURST] = rburst_q[i];
				r[CSD_CTL_WBURST] = wburst_q[i];
			end
		endcase
		return r;
	endfunction : reg_word

	// register bus: address and data may arrive in either order
	logic aw_held_q, w_held_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [5:0] wdec;
	logic wr_fire;
	logic [31:0] wr_word;

	assign wdec = reg_decode(awaddr_q);
	assign wr_fire = aw_held_q && w_held_q && !o_s_axi_bvalid;
	assign wr_word = strb_merge(reg_word(wdec[4:2], wdec[1:0]), wdata_q, wstrb_q);

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 8'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= CSD_RESP_OKAY;
		end else begin
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= i_s_axi_wdata;
				wstrb_q <= i_s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp <= wdec[5] ? CSD_RESP_OKAY : CSD_RESP_SLVERR;
			end else if (o_s_axi_bvalid && i_s_axi_bready) begin
				o_s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready <= 1'b0;
		end else begin
			o_s_axi_awready <= !aw_held_q && !(i_s_axi_awvalid && o_s_axi_awready);
			o_s_axi_wready <= !w_held_q && !(i_s_axi_wvalid && o_s_axi_wready);
		end
	end

	// configuration write; select zero's reset value comes from the straps
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			for (int i = 0; i < NUM_SEL; i++) begin
				base_q[i] <= 16'h0;
				mask_q[i] <= 16'h0;
				ws_q[i] <= CSD_WS_NONE;
				pw_q[i] <= CSD_PW_32;
			end
			vld_q <= '0;
			cpu_q <= '0;
			aa_q <= '0;
			mode_q <= '0;
			rburst_q <= '0;
			wburst_q <= '0;
			aa_q[0] <= i_boot_strap[CSD_STRAP_AA];
			ws_q[0] <= i_boot_strap[CSD_STRAP_AA] ? CSD_BOOT_WS : CSD_WS_NONE;
			pw_q[0] <= i_boot_strap[1] ? CSD_PW_16 : i_boot_strap[1:0];
		end else if (wr_fire && wdec[5]) begin
			case (wdec[1:0])
				CSD_KIND_BASE: base_q[wdec[4:2]] <= wr_word[CSD_HI_LSB +: 16];
				CSD_KIND_MASK: begin
					mask_q[wdec[4:2]] <= wr_word[CSD_HI_LSB +: 16];
					cpu_q[wdec[4:2]] <= wr_word[CSD_MSK_CPU];
					vld_q[wdec[4:2]] <= wr_word[CSD_MSK_VLD];
				end
				default: begin
					ws_q[wdec[4:2]] <= wr_word[CSD_CTL_WS_LSB +: 4];
					aa_q[wdec[4:2]] <= wr_word[CSD_CTL_AA];
					pw_q[wdec[4:2]] <= wr_word[CSD_CTL_PW_LSB +: 2];
					mode_q[wdec[4:2]] <= wr_word[CSD_CTL_MODE];
					rburst_q[wdec[4:2]] <= wr_word[CSD_CTL_RBURST];
					wburst_q[wdec[4:2]] <= wr_word[CSD_CTL_WBURST];
				end
			endcase
		end
	end

	// register read, one cycle after the address is taken
	logic [5:0] rdec;
	assign rdec = reg_decode(i_s_axi_araddr);

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h0;
			o_s_axi_rresp <= CSD_RESP_OKAY;
			o_s_axi_arready <= 1'b0;
		end else begin
			o_s_axi_arready <= !o_s_axi_rvalid && !(i_s_axi_arvalid && o_s_axi_arready);
			if (i_s_axi_arvalid && o_s_axi_arready) begin
				o_s_axi_rvalid <= 1'b1;
				o_s_axi_rdata <= rdec[5] ? reg_word(rdec[4:2], rdec[1:0]) : 32'h0;
				o_s_axi_rresp <= rdec[5] ? CSD_RESP_OKAY : CSD_RESP_SLVERR;
			end else if (o_s_axi_rvalid && i_s_axi_rready) begin
				o_s_axi_rvalid <= 1'b0;
			end
		end
	end

	// address decode of the current access
	logic boot_mode;
	logic [NUM_SEL-1:0] match;
	logic any_match, multi_match, single;
	logic [2:0] sel_idx;
	assign boot_mode = !vld_q[0];

	always_comb begin
		sel_idx = 3'h0;
		for (int i = NUM_SEL - 1; i >= 0; i--) begin
			// external masters qualify like the core; processor space needs the enable
			match[i] = vld_q[i] && (((i_acc_addr[31:16] ^ base_q[i]) & ~mask_q[i]) == 16'h0)
				&& (!i_acc_cpu_space || cpu_q[i]);
			if (boot_mode) begin
				match[i] = (i == 0);
			end
			if (match[i]) begin
				sel_idx = 3'(i);
			end
		end
	end

	assign any_match = |match;
	assign multi_match = (match & (match - 1'b1)) != '0;
	assign single = any_match && !multi_match;

	csd_lane_if lane ();
	assign lane.size = i_acc_size;
	assign lane.addr_lo = i_acc_addr[1:0];
	assign lane.port_width = single ? pw_q[sel_idx] : CSD_PW_32;
	assign lane.mode = single ? mode_q[sel_idx] : 1'b0;
	assign lane.write = i_acc_write;
	csd_lane_decoder u_lane (
		.lane(lane)
	);

	// bus cycle: decode is frozen at the first edge of the access
	csd_state_type state_q;
	logic cyc_write_q, cyc_any_q, rd_cond, ack_en_q;
	logic [3:0] cyc_ws_q;
	// one spare bit so a count of fifteen waits cannot wrap into a second acknowledge
	logic [4:0] wait_cnt_q;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			state_q <= CSD_IDLE;
			o_select_n <= '1;
			o_lane_strobe_n <= CSD_LANES_OFF;
			o_cyc_port_width <= CSD_PW_32;
			o_cyc_burst_en <= 1'b0;
			o_cyc_ext_term <= 1'b0;
			cyc_write_q <= 1'b0;
			cyc_any_q <= 1'b0;
			ack_en_q <= 1'b0;
			cyc_ws_q <= CSD_WS_NONE;
		end else begin
			case (state_q)
				CSD_IDLE: begin
					if (i_acc_valid) begin
						state_q <= CSD_ACTIVE;
						o_select_n <= ~match;
						o_lane_strobe_n <= lane.lane_n;
						cyc_write_q <= i_acc_write;
						cyc_any_q <= any_match;
						cyc_ws_q <= ws_q[sel_idx];
						if (single) begin
							o_cyc_port_width <= pw_q[sel_idx];
							o_cyc_burst_en <= i_acc_write ? wburst_q[sel_idx] : rburst_q[sel_idx];
							o_cyc_ext_term <= !aa_q[sel_idx];
							ack_en_q <= aa_q[sel_idx];
						end else begin
							// a dram hit alone leaves termination to the dram side
							o_cyc_port_width <= CSD_PW_32;
							o_cyc_burst_en <= 1'b0;
							o_cyc_ext_term <= multi_match || !i_dram_hit;
							ack_en_q <= 1'b0;
						end
					end
				end
				CSD_ACTIVE: begin
					if (!i_acc_valid) begin
						state_q <= CSD_IDLE;
						o_select_n <= '1;
						o_lane_strobe_n <= CSD_LANES_OFF;
						o_cyc_burst_en <= 1'b0;
						o_cyc_ext_term <= 1'b0;
						cyc_any_q <= 1'b0;
						ack_en_q <= 1'b0;
					end
				end
				default: state_q <= CSD_IDLE;
			endcase
		end
	end

	// internal termination after the programmed number of waits
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			wait_cnt_q <= 5'h0;
			o_cyc_ack <= 1'b0;
		end else begin
			o_cyc_ack <= 1'b0;
			if (state_q == CSD_IDLE) begin
				wait_cnt_q <= 5'h0;
			end else if (ack_en_q && wait_cnt_q <= {1'b0, cyc_ws_q}) begin
				wait_cnt_q <= wait_cnt_q + 5'h1;
				o_cyc_ack <= (wait_cnt_q == {1'b0, cyc_ws_q});
			end
		end
	end

	// read strobe: condition set at the rising edge, driven at the next falling edge
	assign rd_cond = (state_q == CSD_ACTIVE) && cyc_any_q && !cyc_write_q;
	always_ff @(negedge i_core_clk) begin
		if (!i_rst_n) begin
			o_read_strobe_n <= 1'b1;
		end else begin
			o_read_strobe_n <= !rd_cond;
		end
	end

	property p_rd_needs_sel;
		@(posedge i_core_clk) disable iff (!i_rst_n) !o_read_strobe_n |-> !(&o_select_n);
	endproperty
	a_rd_needs_sel: assert property (p_rd_needs_sel) else $error("read strobe without select");

	property p_rd_half;
		@(posedge i_core_clk) disable iff (!i_rst_n) $rose(rd_cond) |=> !o_read_strobe_n;
	endproperty
	a_rd_half: assert property (p_rd_half) else $error("read strobe late");

	property p_boot_only0;
		@(posedge i_core_clk) disable iff (!i_rst_n)
			boot_mode && i_acc_valid && state_q == CSD_IDLE |=> o_select_n == {{(NUM_SEL-1){1'b1}}, 1'b0};
	endproperty
	a_boot_only0: assert property (p_boot_only0) else $error("boot select wrong");

	property p_pw8;
		@(posedge i_core_clk) disable iff (!i_rst_n)
			state_q == CSD_ACTIVE && o_cyc_port_width == CSD_PW_8 && o_lane_strobe_n != CSD_LANES_OFF
			|-> o_lane_strobe_n == 4'he;
	endproperty
	a_pw8: assert property (p_pw8) else $error("8-bit lanes wrong");

	property p_pw16_byte;
		@(posedge i_core_clk) disable iff (!i_rst_n)
			lane.port_width == CSD_PW_16 && lane.size == CSD_SZ_BYTE && !lane.mode
			|-> lane.lane_n == (lane.addr_lo[0] ? 4'hd : 4'he);
	endproperty
	a_pw16_byte: assert property (p_pw16_byte) else $error("16-bit byte lane wrong");

	property p_pw32_word;
		@(posedge i_core_clk) disable iff (!i_rst_n)
			lane.port_width == CSD_PW_32 && lane.size == CSD_SZ_WORD && lane.write
			|-> lane.lane_n == (lane.addr_lo[1] ? 4'h3 : 4'hc);
	endproperty
	a_pw32_word: assert property (p_pw32_word) else $error("32-bit word lanes wrong");

	property p_multi;
		@(posedge i_core_clk) disable iff (!i_rst_n)
			i_acc_valid && state_q == CSD_IDLE && multi_match
			|=> o_cyc_ext_term && !o_cyc_burst_en && o_cyc_port_width == CSD_PW_32;
	endproperty
	a_multi: assert property (p_multi) else $error("multi match cycle wrong");

	property p_ack_wait;
		@(posedge i_core_clk) disable iff (!i_rst_n)
			$rose(state_q == CSD_ACTIVE) && ack_en_q && cyc_ws_q == 4'h0 ##0 i_acc_valid
			|-> ##1 o_cyc_ack;
	endproperty
	a_ack_wait: assert property (p_ack_wait) else $error("zero-wait acknowledge late");

	property p_ack_count;
		@(posedge i_core_clk) disable iff (!i_rst_n)
			o_cyc_ack |-> $past(wait_cnt_q) == {1'b0, cyc_ws_q};
	endproperty
	a_ack_count: assert property (p_ack_count) else $error("wait count wrong");

	property p_strap;
		@(posedge i_core_clk) disable iff (!i_rst_n)
			$rose(i_rst_n) |-> aa_q[0] == $past(i_boot_strap[2])
			&& ws_q[0] == ($past(i_boot_strap[2]) ? CSD_BOOT_WS : CSD_WS_NONE);
	endproperty
	a_strap: assert property (p_strap) else $error("boot acknowledge strap wrong");

	c_boot: cover property (@(posedge i_core_clk) boot_mode && state_q == CSD_ACTIVE);
	c_multi: cover property (@(posedge i_core_clk) i_acc_valid && multi_match);
	c_ack: cover property (@(posedge i_core_clk) o_cyc_ack && cyc_ws_q != 4'h0);
	c_read: cover property (@(posedge i_core_clk) !o_read_strobe_n && !boot_mode);
endmodule : csd_chip_select

//--- verification/csd_mem_model.sv
// Purpose: far-side memory bus model that holds the boot levels on data lines 7:5
// Assumes: the lines carry no pull resistor once the model lets go of them
// Notes: released lines toggle every cycle, so a stale strap never passes for a held one
`timescale 1ns/1ps
module csd_mem_model (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [2:0] i_strap_cfg,
	output logic [2:0] o_data_hi
);
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n)
			o_data_hi <= i_strap_cfg;
		else
			o_data_hi <= ~o_data_hi;
	end
endmodule : csd_mem_model

//--- verification/tb.sv
// Purpose: self-checking bench for the chip-select decoder
// Assumes: AXI4-Lite register access, one access cycle at a time
// Notes: wait-state timing is judged by difference, so the fixed ack offset cancels
`timescale 1ns/1ps
module tb;
	import csd_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, wr_acc = 1'b0, cpu = 1'b0, ext_m = 1'b0;
	logic dram = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
	logic rready = 1'b0;
	logic [2:0] strap = 3'h5;
	logic [2:0] data_hi;
	logic [31:0] addr = '0, wdata = '0, rdata;
	logic [1:0] size = '0, port_w, bresp, rresp;
	logic [7:0] awaddr = '0, araddr = '0, sel_n;
	logic [3:0] lane_n;
	logic rd_n, burst, ext_term, ack, awready, wready, bvalid, arready, rvalid;
	int num_errors = 0, checks_done = 0, cycles = 0;

	always #2.5 clk = ~clk;

	csd_mem_model u_csd_mem_model (.i_core_clk(clk), .i_rst_n(rst_n), .i_strap_cfg(strap),
		.o_data_hi(data_hi));

	csd_chip_select #(.NUM_SEL(8)) u_csd_chip_select (.i_core_clk(clk), .i_rst_n(rst_n),
		.i_boot_strap(data_hi), .i_acc_valid(valid), .i_acc_addr(addr), .i_acc_write(wr_acc),
		.i_acc_size(size), .i_acc_cpu_space(cpu), .i_acc_ext_master(ext_m),
		.i_dram_hit(dram), .o_select_n(sel_n), .o_read_strobe_n(rd_n),
		.o_lane_strobe_n(lane_n), .o_cyc_port_width(port_w), .o_cyc_burst_en(burst),
		.o_cyc_ext_term(ext_term), .o_cyc_ack(ack), .i_s_axi_awaddr(awaddr),
		.i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
		.o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
		.i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
		.o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready));

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			$display("FAIL %0t run did not finish", $time);
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// expected lane strobes; bit 0 serves data bits 31:24
	function automatic logic [3:0] lanes_exp(input logic [1:0] pw, sz, a);
		logic [3:0] on;
		if (pw == CSD_PW_8)
			on = 4'h1;
		else if (pw == CSD_PW_16)
			on = (sz != CSD_SZ_BYTE) ? 4'h3 : (a[0] ? 4'h2 : 4'h1);
		else if (sz == CSD_SZ_BYTE)
			on = 4'h1 << a;
		else if (sz == CSD_SZ_WORD)
			on = a[1] ? 4'hc : 4'h3;
		else
			on = 4'hf;
		return ~on;
	endfunction : lanes_exp

	// waits, auto-ack, width, lane mode, both bursts on
	function automatic logic [31:0] ctl(input logic [3:0] ws, input logic aa,
			input logic [1:0] pw, input logic md);
		return {18'h0, ws, 1'b0, aa, pw, md, 2'h3, 3'h0};
	endfunction : ctl

	task automatic do_reset(input logic [2:0] st);
		@(posedge clk);
		rst_n <= 1'b0;
		strap <= st;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask : do_reset

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_on, w_on;
		aw_on = 1'b1;
		w_on = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (aw_on && awready === 1'b1) begin
				aw_on = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_on && wready === 1'b1) begin
				w_on = 1'b0;
				wvalid <= 1'b0;
			end
		end while (aw_on || w_on || bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, er, "write response");
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, ed, "read data");
		chk(rresp, er, "read response");
	endtask : axi_rd

	// x in an expected value means that output is left open by the rules
	task automatic acc(input logic [31:0] ad, input logic w, input logic [1:0] sz,
			input logic [7:0] es, input logic [3:0] el, input logic [1:0] ep,
			input logic ee, input logic eb, output int n);
		@(posedge clk);
		valid <= 1'b1;
		addr <= ad;
		wr_acc <= w;
		size <= sz;
		@(posedge clk);
		@(negedge clk);
		#1;
		chk(sel_n, es, "selects");
		if (el !== 4'hx)
			chk(lane_n, el, "lane strobes");
		if (ep !== 2'hx)
			chk(port_w, ep, "port width");
		if (eb !== 1'bx)
			chk(burst, eb, "burst");
		chk(ext_term, ee, "termination");
		chk(rd_n, !(!w && es != 8'hff), "read strobe");
		n = 0;
		while (n < 40 && ack !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		valid <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		#1;
		chk(sel_n, 8'hff, "selects after cycle");
		chk(rd_n, 1'b1, "read strobe after cycle");
		// hand back on a rising edge so the caller's next input change lands there
		@(posedge clk);
	endtask : acc

	initial begin
		int nb, n;
		logic [1:0] pw;
		logic [7:0] ra;
		do_reset(3'h5);
		chk(sel_n, 8'hff, "selects in reset");
		acc(32'h7654_3210, 0, CSD_SZ_LONG, 8'hfe, 4'he, CSD_PW_8, 0, 1'bx, nb);
		chk(nb < 40, 1, "boot ack");
		$display("test boot straps with auto ack done");
		do_reset(3'h2);
		for (int i = 0; i < 3; i++) begin
			ra = 8'h8c + 8'(4 * i);
			axi_wr(ra, 32'hffff_ffff, CSD_RESP_OKAY);
			axi_rd(ra, i == 0 ? 32'hffff_0000 : (i == 1 ? 32'hffff_0003 : 32'h3df8), 0);
		end
		axi_rd(8'he0, 32'h0, CSD_RESP_SLVERR);
		axi_wr(8'h81, 32'h1, CSD_RESP_SLVERR);
		axi_wr(8'h8c, 32'h1000_ffff, CSD_RESP_OKAY);
		axi_wr(8'h90, 32'h0001_0001, CSD_RESP_OKAY);
		axi_rd(8'h90, 32'h0001_0001, CSD_RESP_OKAY);
		acc(32'h1000_0000, 0, CSD_SZ_BYTE, 8'hfe, 4'he, CSD_PW_16, 1, 1'bx, n);
		chk(n, 40, "no boot ack");
		axi_wr(8'h80, 32'hf000_0000, CSD_RESP_OKAY);
		axi_wr(8'h84, 32'h0000_0001, CSD_RESP_OKAY);
		$display("test registers and boot mode done");
		for (int p = 0; p < 3; p++) begin
			pw = p == 0 ? CSD_PW_32 : (p == 1 ? CSD_PW_16 : CSD_PW_8);
			axi_wr(8'h94, ctl(4'h1, 1, pw, 0), CSD_RESP_OKAY);
			for (int s = 0; s < 4; s++)
				for (int a = 0; a < 4; a++)
					if (!(s != 0 && a % 2 == 1) && !(s >= 2 && p == 0 && a != 0)) begin
						acc(32'h1001_0000 + a, 0, 2'(s), 8'hfd, lanes_exp(pw, 2'(s), 2'(a)), pw, 0, 1, n);
						chk(nb - n, 14, "wait states");
					end
		end
		$display("test lane strobes done");
		axi_wr(8'h94, ctl(4'h1, 1, CSD_PW_32, 1), CSD_RESP_OKAY);
		acc(32'h1000_0001, 0, CSD_SZ_BYTE, 8'hfd, 4'hf, CSD_PW_32, 0, 1, n);
		acc(32'h1000_0001, 1, CSD_SZ_BYTE, 8'hfd, 4'hd, CSD_PW_32, 0, 1, n);
		acc(32'h1002_0000, 0, CSD_SZ_LONG, 8'hff, 4'hx, CSD_PW_32, 1, 0, n);
		chk(n, 40, "no ack without match");
		dram <= 1'b1;
		acc(32'h1002_0000, 0, CSD_SZ_LONG, 8'hff, 4'hx, 2'hx, 0, 1'bx, n);
		dram <= 1'b0;
		cpu <= 1'b1;
		acc(32'h1000_0000, 0, CSD_SZ_LONG, 8'hff, 4'hx, CSD_PW_32, 1, 0, n);
		axi_wr(8'h90, 32'h0001_0003, CSD_RESP_OKAY);
		acc(32'h1000_0000, 0, CSD_SZ_LONG, 8'hfd, 4'hf, CSD_PW_32, 0, 1, n);
		cpu <= 1'b0;
		ext_m <= 1'b1;
		acc(32'h1000_0000, 1, CSD_SZ_LONG, 8'hfd, 4'h0, CSD_PW_32, 0, 1, n);
		ext_m <= 1'b0;
		$display("test lane mode, no match and cycle kinds done");
		for (int i = 2; i < 8; i++) begin
			ra = 8'h80 + 8'(12 * i);
			axi_wr(ra, {16'h2000 + 16'(i), 16'h0}, CSD_RESP_OKAY);
			axi_wr(ra + 8'h4, 32'h1, CSD_RESP_OKAY);
			axi_wr(ra + 8'h8, ctl(4'h0, 1, CSD_PW_32, 0), CSD_RESP_OKAY);
			acc({16'h2000 + 16'(i), 16'h0}, 0, CSD_SZ_LONG, ~(8'h1 << i), 4'h0, CSD_PW_32, 0, 1, n);
			chk(nb - n, 15, "zero wait states");
		end
		axi_wr(8'h98, 32'h1000_0000, CSD_RESP_OKAY);
		acc(32'h1000_0000, 0, CSD_SZ_LONG, 8'hf9, 4'hx, CSD_PW_32, 1, 0, n);
		chk(n, 40, "no ack on multiple match");
		$display("test all selects and multiple match done");
		end_of_test();
	end
endmodule : tb
